// file: core/eeprom_front_pkg.sv
package eeprom_front_pkg;

  // Device-type field of the address word, top four bits
  localparam logic [3:0] DEV_TYPE = 4'hA;
  localparam int BYTE_BITS = 8;
  localparam int ACK_SLOT = 8;

  // Internal write time, 5 ms maximum
  localparam int MCLK_HZ = 20_000_000;
  localparam int INTERNAL_WRITE_TIME_US = 5000;
  localparam int WRITE_CYCLES = (MCLK_HZ / 1_000_000) * INTERNAL_WRITE_TIME_US;
  localparam int WCNT_W = 17;

  localparam logic [16:0] ADDR_RESET = 17'h0_0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // Link-side protocol phase
  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_DEVADR = 3'b001,
    PH_ADRHI = 3'b010,
    PH_ADRLO = 3'b011,
    PH_WDATA = 3'b100,
    PH_RDATA = 3'b101,
    PH_IGNORE = 3'b110
  } phase_t;

  // Memory write request from the front end
  typedef struct packed {
    logic [16:0] addr;
    logic [7:0] data;
  } mem_wr_t;

endpackage : eeprom_front_pkg

// file: core/eeprom_front.sv
// Functional notes
// - Data changes only while clock low; changes while high are start or stop.
// - Falling data with clock high is a start; start precedes every command.
// - Rising data with clock high is a stop; stop after read means standby.
// - Words are eight bits; device pulls data low on the ninth clock.
// - Standby after power-up, after stop in read mode, after write cycle ends.
// - Start, nine clocks, start, stop leaves the device ready for new transaction.
// - Each transaction opens with an eight-bit device address word after start.
// - Address word accepted only when top four bits hold the fixed device type.
// - Two select bits must equal the two select strap pins.
// - An unconnected select pin counts as low in the comparison.
// - Address word bit one is the top bit of the memory word address.
// - Last address word bit high means read, low means write.
// - Match gives acknowledge; mismatch gives none and returns to standby.
// - Write-protect pin high blocks every write to the memory array.
// - Self-timed write starts at stop ending a write, done within 5 ms.
// - Write sends high then low address byte; every byte is acknowledged.
// - Multi-byte write increments low eight bits only, wrapping within page.
// - During the write cycle the address word is not acknowledged.
// - Address counter keeps last address plus one; reads wrap at memory end.
`timescale 1ns/1ps
`default_nettype none
module eeprom_front
  import eeprom_front_pkg::*;
(
  // System
  input wire logic mclk,
  input wire logic arst_n,
  // Link
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Straps and protection, pulled low when floating
  input wire logic chip_select_strap_low,
  input wire logic chip_select_strap_high,
  input wire logic write_protect,
  // Memory array side
  output logic mem_wr_valid,
  output mem_wr_t mem_wr,
  output logic [16:0] mem_rd_addr,
  input wire logic [7:0] mem_rd_data,
  // Status
  output logic busy,
  output logic standby
);

  // ---------------- Link domain (scl) ----------------
  // Pin straps synchronised into the link domain
  logic [1:0] sel_s1_ff, sel_s2_ff;
  logic wp_s1_ff, wp_s2_ff;
  // Busy level from mclk domain
  logic busy_s1_ff, busy_s2_ff;

  // Start and stop toggles sampled on data edges while clock is high
  logic start_tgl_ff, stop_tgl_ff;

  always_ff @(negedge sda_in or negedge arst_n) begin
    if (!arst_n) begin
      start_tgl_ff <= 1'b0;
    end else if (scl) begin
      start_tgl_ff <= ~start_tgl_ff;
    end
  end

  always_ff @(posedge sda_in or negedge arst_n) begin
    if (!arst_n) begin
      stop_tgl_ff <= 1'b0;
    end else if (scl) begin
      stop_tgl_ff <= ~stop_tgl_ff;
    end
  end

  // Last start toggle consumed at a rising clock edge
  logic start_ack_ff;
  wire new_start = start_tgl_ff != start_ack_ff;

  phase_t phase_ff, nxt_phase;
  logic [3:0] bit_cnt_ff;
  logic [7:0] shift_ff;
  logic [16:0] addr_ff;
  logic rd_mode_ff;
  logic ack_pend_ff;
  logic wr_any_ff;
  logic [7:0] tx_ff;

  wire [7:0] rx_byte = {shift_ff[6:0], sda_in};
  wire in_ack_slot = bit_cnt_ff == 4'(ACK_SLOT);
  wire [1:0] sel_pins = sel_s2_ff;
  wire type_ok = rx_byte[7:4] == DEV_TYPE;
  wire sel_ok = rx_byte[3:2] == sel_pins;
  wire adr_match = type_ok && sel_ok && !busy_s2_ff;

  function automatic logic [16:0] page_inc(input logic [16:0] a);
    page_inc = {a[16:8], a[7:0] + 8'h01};
  endfunction : page_inc

  // Last written byte, held for the system domain
  mem_wr_t wr_hold_ff;

  always_ff @(posedge scl or negedge arst_n) begin
    if (!arst_n) begin
      sel_s1_ff <= 2'b00;
      sel_s2_ff <= 2'b00;
      wp_s1_ff <= 1'b0;
      wp_s2_ff <= 1'b0;
      busy_s1_ff <= 1'b0;
      busy_s2_ff <= 1'b0;
    end else begin
      sel_s1_ff <= {chip_select_strap_high, chip_select_strap_low};
      sel_s2_ff <= sel_s1_ff;
      wp_s1_ff <= write_protect;
      wp_s2_ff <= wp_s1_ff;
      busy_s1_ff <= busy;
      busy_s2_ff <= busy_s1_ff;
    end
  end

  // Receive bit engine and phase control on rising clock; transmit bits are driven on the falling clock
  always_ff @(posedge scl or negedge arst_n) begin
    if (!arst_n) begin
      start_ack_ff <= 1'b0;
      phase_ff <= PH_IDLE;
      bit_cnt_ff <= 4'h0;
      shift_ff <= BYTE_RESET;
      addr_ff <= ADDR_RESET;
      rd_mode_ff <= 1'b0;
      ack_pend_ff <= 1'b0;
      wr_hold_ff <= '0;
      wr_any_ff <= 1'b0;
    end else if (new_start) begin
      // Start mid-frame restarts framing, covers soft reset
      start_ack_ff <= start_tgl_ff;
      phase_ff <= PH_DEVADR;
      bit_cnt_ff <= 4'h1;
      shift_ff <= {7'h00, sda_in};
      ack_pend_ff <= 1'b0;
      wr_any_ff <= 1'b0;
    end else if (phase_ff == PH_IDLE || phase_ff == PH_IGNORE) begin
      bit_cnt_ff <= 4'h0;
    end else if (in_ack_slot) begin
      bit_cnt_ff <= 4'h0;
      ack_pend_ff <= 1'b0;
      // Device-address slot of a read does not advance the counter
      if (phase_ff == PH_RDATA && !ack_pend_ff) begin
        addr_ff <= addr_ff + 17'h0_0001;
        if (sda_in) begin
          phase_ff <= PH_IGNORE;
        end
      end
    end else begin
      bit_cnt_ff <= bit_cnt_ff + 4'h1;
      shift_ff <= rx_byte;
      if (bit_cnt_ff == 4'(BYTE_BITS - 1)) begin
        phase_ff <= nxt_phase;
        ack_pend_ff <= nxt_phase != PH_IGNORE && nxt_phase != PH_RDATA;
        unique case (phase_ff)
          PH_DEVADR: begin
            if (adr_match) begin
              addr_ff[16] <= rx_byte[1];
              rd_mode_ff <= rx_byte[0];
              ack_pend_ff <= 1'b1;
            end
          end
          PH_ADRHI: addr_ff[15:8] <= rx_byte;
          PH_ADRLO: addr_ff[7:0] <= rx_byte;
          PH_WDATA: begin
            wr_hold_ff <= '{addr: addr_ff, data: rx_byte};
            addr_ff <= page_inc(addr_ff);
            wr_any_ff <= !wp_s2_ff;
          end
          default: begin
          end
        endcase
      end
    end
  end

  assign nxt_phase = (phase_ff == PH_DEVADR) ?
      (!adr_match ? PH_IGNORE : (rx_byte[0] ? PH_RDATA : PH_ADRHI)) :
      (phase_ff == PH_ADRHI) ? PH_ADRLO :
      (phase_ff == PH_ADRLO) ? PH_WDATA :
      (phase_ff == PH_WDATA) ? PH_WDATA :
      (phase_ff == PH_RDATA) ? PH_RDATA : PH_IGNORE;

  // One-bit ignore level, so it crosses to the system domain cleanly
  logic ignore_ff;

  always_ff @(posedge scl or negedge arst_n) begin
    if (!arst_n) begin
      ignore_ff <= 1'b0;
    end else begin
      ignore_ff <= phase_ff == PH_IGNORE;
    end
  end

  // Drive out on falling clock; only ever low
  always_ff @(negedge scl or negedge arst_n) begin
    if (!arst_n) begin
      sda_oe <= 1'b0;
      tx_ff <= BYTE_RESET;
    end else if (ack_pend_ff && in_ack_slot) begin
      sda_oe <= 1'b1;
    end else if (phase_ff == PH_RDATA && bit_cnt_ff < 4'(ACK_SLOT)) begin
      if (bit_cnt_ff == 4'h0) begin
        tx_ff <= {mem_rd_data[6:0], 1'b0};
        sda_oe <= !mem_rd_data[7];
      end else begin
        tx_ff <= {tx_ff[6:0], 1'b0};
        sda_oe <= !tx_ff[7];
      end
    end else begin
      sda_oe <= 1'b0;
    end
  end

  // Open drain: value is always low while enabled
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
    end
  end

  // ---------------- System domain (mclk) ----------------
  // Start and stop toggles brought over through three flip-flops, ignore level through two
  logic sta_s1_ff, sta_s2_ff, sta_s3_ff;
  logic stp_s1_ff, stp_s2_ff, stp_s3_ff;
  logic ign_s1_ff, ign_s2_ff;
  logic active_ff;
  logic [WCNT_W-1:0] wcnt_ff;
  logic [16:0] rd_addr_s1_ff;

  wire start_evt = sta_s2_ff != sta_s3_ff;
  wire stop_evt = stp_s2_ff != stp_s3_ff;
  // Write flags stand still once a stop has left the link clock high
  wire wr_ready = wr_any_ff && !rd_mode_ff;
  wire go_evt = stop_evt && wr_ready && !busy;
  wire link_idle = (!active_ff && !start_evt) || ign_s2_ff;
  wire wcnt_done = wcnt_ff == '0;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sta_s1_ff <= 1'b0;
      sta_s2_ff <= 1'b0;
      sta_s3_ff <= 1'b0;
      stp_s1_ff <= 1'b0;
      stp_s2_ff <= 1'b0;
      stp_s3_ff <= 1'b0;
      ign_s1_ff <= 1'b0;
      ign_s2_ff <= 1'b0;
    end else begin
      sta_s1_ff <= start_tgl_ff;
      sta_s2_ff <= sta_s1_ff;
      sta_s3_ff <= sta_s2_ff;
      stp_s1_ff <= stop_tgl_ff;
      stp_s2_ff <= stp_s1_ff;
      stp_s3_ff <= stp_s2_ff;
      ign_s1_ff <= ignore_ff;
      ign_s2_ff <= ign_s1_ff;
    end
  end

  // Frame open between a start and the following stop
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      active_ff <= 1'b0;
    end else if (stop_evt) begin
      active_ff <= 1'b0;
    end else if (start_evt) begin
      active_ff <= 1'b1;
    end
  end

  // Read address follows the link counter, settled between bytes
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rd_addr_s1_ff <= ADDR_RESET;
      mem_rd_addr <= ADDR_RESET;
    end else begin
      rd_addr_s1_ff <= addr_ff;
      mem_rd_addr <= rd_addr_s1_ff;
    end
  end

  // Self-timed write cycle, started by the stop itself
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      busy <= 1'b0;
      wcnt_ff <= '0;
      mem_wr_valid <= 1'b0;
      mem_wr <= '0;
      standby <= 1'b1;
    end else begin
      mem_wr_valid <= go_evt;
      if (go_evt) begin
        mem_wr <= wr_hold_ff;
        busy <= 1'b1;
        wcnt_ff <= WCNT_W'(WRITE_CYCLES - 1);
        standby <= 1'b0;
      end else if (busy) begin
        if (wcnt_done) begin
          busy <= 1'b0;
          standby <= 1'b1;
        end else begin
          wcnt_ff <= wcnt_ff - 1'b1;
        end
      end else begin
        standby <= link_idle;
      end
    end
  end

endmodule : eeprom_front
`default_nettype wire

// file: sim/eeprom_front_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module eeprom_front_asserts
  import eeprom_front_pkg::*;
(
  // System
  input wire logic mclk,
  input wire logic arst_n,
  // Link and straps
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic write_protect,
  // Memory side and status
  input wire logic mem_wr_valid,
  input wire mem_wr_t mem_wr,
  input wire logic busy,
  input wire logic standby
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  sequence wr_kick;
    mem_wr_valid ##[0:4] busy;
  endsequence
  sda_low_a: assert property (sda_out == 1'b0)
    else $error("data line driven high");
  reset_idle_a: assert property ($rose(arst_n) |-> standby && !busy && !sda_oe)
    else $error("not idle after reset");
  wr_pulse_a: assert property (mem_wr_valid |=> !mem_wr_valid)
    else $error("write strobe longer than one cycle");
  wr_start_a: assert property (mem_wr_valid |-> wr_kick)
    else $error("write cycle not started");
  busy_hold_a: assert property ($rose(busy) |-> busy [*8])
    else $error("write cycle too short");
  wp_block_a: assert property (mem_wr_valid |-> !write_protect)
    else $error("write while protected");
  busy_quiet_a: assert property (busy |-> !sda_oe)
    else $error("answer during write cycle");
  wr_hold_a: assert property (busy && $past(busy) |-> $stable(mem_wr))
    else $error("write word changed in write cycle");
endmodule : eeprom_front_asserts
bind eeprom_front eeprom_front_asserts i_eeprom_front_asserts (.mclk(mclk), .arst_n(arst_n),
  .sda_out(sda_out), .sda_oe(sda_oe), .write_protect(write_protect),
  .mem_wr_valid(mem_wr_valid), .mem_wr(mem_wr), .busy(busy), .standby(standby));
`default_nettype wire

// file: sim/bus_master.sv
`timescale 1ns/1ps
`default_nettype none
module bus_master (
  // Bus lines
  output logic scl,
  output logic sda_drv,
  input wire logic sda_line
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // One clock, data set mid-low
  task automatic put(input logic b);
    scl = 1'b0;
    #3.75 sda_drv = b;
    #3.75 scl = 1'b1;
    #7.5;
  endtask : put
  // Released line, sampled late in high
  task automatic get(output logic b);
    put(1'b1);
    b = sda_line;
  endtask : get
  task automatic start();
    if (!(scl && sda_line)) put(1'b1);
    sda_drv = 1'b0;
    #7.5;
  endtask : start
  task automatic stop();
    put(1'b0);
    sda_drv = 1'b1;
    #7.5;
  endtask : stop
  task automatic send(input logic [7:0] d, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) put(d[i]);
    get(a);
    ack = !a;
  endtask : send
  task automatic recv(input logic last, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) get(d[i]);
    put(last);
  endtask : recv
  task automatic soft_reset();
    start();
    repeat (9) put(1'b1);
    start();
    stop();
  endtask : soft_reset
endmodule : bus_master
`default_nettype wire

// file: sim/test_serial_eeprom_bus_front_end.sv
`timescale 1ns/1ps
`default_nettype none
module test_serial_eeprom_bus_front_end
  import eeprom_front_pkg::*;
;
  typedef struct packed {logic sh; logic sl; logic [7:0] adr; logic ack;} row_t;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic sh = 1'b0;
  logic sl = 1'b0;
  logic wp = 1'b0;
  logic scl, sda_drv, sda_oe, sda_out, mem_wr_valid, busy, standby, ack;
  logic [7:0] d;
  logic [4:0] acks;
  mem_wr_t mem_wr;
  int errors = 0;
  int checks = 0;
  int wr_cnt = 0;
  // Pull-up, device only pulls low
  wire logic sda_line = sda_drv & ~(sda_oe & ~sda_out);
  row_t rows [8] = '{'{1'b0, 1'b0, 8'hA1, 1'b1}, '{1'b0, 1'b0, 8'hA3, 1'b1},
    '{1'b0, 1'b1, 8'hA5, 1'b1}, '{1'b1, 1'b0, 8'hA9, 1'b1}, '{1'b1, 1'b1, 8'hAD, 1'b1},
    '{1'b0, 1'b0, 8'hA5, 1'b0}, '{1'b0, 1'b0, 8'hB1, 1'b0}, '{1'b1, 1'b1, 8'hA1, 1'b0}};
  always #25 mclk = ~mclk;
  always @(posedge mclk) if (mem_wr_valid === 1'b1) wr_cnt <= wr_cnt + 1;
  bus_master i_bus_master (.scl(scl), .sda_drv(sda_drv), .sda_line(sda_line));
  eeprom_front i_eeprom_front (.mclk(mclk), .arst_n(arst_n), .scl(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .chip_select_strap_low(sl),
    .chip_select_strap_high(sh), .write_protect(wp), .mem_wr_valid(mem_wr_valid),
    .mem_wr(mem_wr), .mem_rd_addr(), .mem_rd_data(8'hC3), .busy(busy), .standby(standby));
  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick
  task automatic frame(input logic [7:0] adr);
    d = 8'h00;
    i_bus_master.start();
    i_bus_master.send(adr, ack);
    if (ack && adr[0]) i_bus_master.recv(1'b1, d);
    i_bus_master.stop();
  endtask : frame
  // Page write over the page end, A16 set
  task automatic wr_seq();
    logic [7:0] b [5] = '{8'hA2, 8'h12, 8'hFF, 8'h55, 8'h66};
    i_bus_master.start();
    for (int i = 0; i < 5; i++) i_bus_master.send(b[i], acks[i]);
    i_bus_master.stop();
  endtask : wr_seq
  initial begin
    tick(16);
    arst_n = 1'b1;
    check(17'(standby), 17'h0_0001);
    check(17'(busy | sda_oe), 17'h0_0000);
    for (int i = 0; i < 8; i++) begin
      {sh, sl} = {rows[i].sh, rows[i].sl};
      frame(rows[i].adr);
      frame(rows[i].adr);
      check(17'(ack), 17'(rows[i].ack));
      if (rows[i].ack) check(17'(d), 17'h0_00C3);
      tick(6);
      check(17'(standby), 17'h0_0001);
      $display("address row %0d done", i);
    end
    {sh, sl} = 2'b00;
    i_bus_master.soft_reset();
    frame(8'hA1);
    check(17'(ack), 17'h0_0001);
    $display("soft reset test done");
    wp = 1'b1;
    wr_seq();
    tick(20);
    check(17'(wr_cnt), 17'h0_0000);
    $display("protect test done");
    wp = 1'b0;
    wr_seq();
    check(17'(acks), 17'h0_001F);
    for (int k = 0; k < 20 && wr_cnt == 0; k++) tick(1);
    check(17'(wr_cnt), 17'h0_0001);
    if (wr_cnt == 0) stop_test();
    check(mem_wr.addr, 17'h1_1200);
    check(17'(mem_wr.data), 17'h0_0066);
    tick(5);
    check(17'(busy), 17'h0_0001);
    check(17'(standby), 17'h0_0000);
    frame(8'hA1);
    check(17'(ack), 17'h0_0000);
    $display("write test done");
    arst_n = 1'b0;
    tick(2);
    check(17'(busy), 17'h0_0000);
    arst_n = 1'b1;
    $display("reset test done");
    stop_test();
  end
endmodule : test_serial_eeprom_bus_front_end
`default_nettype wire
